/* design/ddr_mode_pkg.sv */
// Package: command strobe layout, mode register fields, burst length codes and timing constants
package ddr_mode_pkg;

	// Mode register field positions in the captured address word
	localparam int BL_LSB       = 0;
	localparam int BL_MSB       = 2;
	localparam int BT_POS       = 3;
	localparam int CL_LSB       = 4;
	localparam int CL_MSB       = 6;
	localparam int TM_POS       = 7;
	localparam int DLLRST_POS   = 8;
	localparam int DLLEN_POS    = 0;
	localparam int ADDR_W       = 13;
	localparam int EXT_W        = 12;

	// Burst length codes
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;

	// Reset values of the captured registers (undefined in silicon)
	localparam logic [12:0] MODE_RST = 13'h0000;
	localparam logic [11:0] EXT_RST  = 12'h000;

	// Mode register write occupancy in cycles
	localparam int MRD_CYCLES = 2;

	// DLL lock wait in cycles after a DLL reset or enable
	localparam int DLL_LOCK_CYCLES = 200;

	// Column counter width of a burst
	localparam int COL_W = 3;

	// Command strobes as sampled at a rising edge, active low
	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
	} cmd_pins_t;

	// Decoded mode register content
	typedef struct packed {
		logic [2:0] burstLen;
		logic       interleaved;
		logic [2:0] readLatency;
		logic       testMode;
		logic       dllReset;
	} mode_fields_t;

endpackage

/* design/burst_addr_gen.sv */
// Burst column address generator for sequential and interleaved order
`timescale 1ns/1ps

module burst_addr_gen #(
	parameter int COLW = 3
) (
	input  wire logic            core_clk,
	input  wire logic            sys_rst,
	input  wire logic            clkEn,
	input  wire logic            start,
	input  wire logic [COLW-1:0] startAddr,
	input  wire logic [COLW-1:0] lenMask,
	input  wire logic            interleaved,
	output logic      [COLW-1:0] colAddr,
	output logic                 colValid
);

	// Elaboration check: the wrap masks need at least a three-bit column
	if (COLW < 3) begin : g_colw_check
		$error("COLW must be at least 3");
	end

	logic [COLW-1:0] base;      // Start offset of burst
	logic [COLW-1:0] beat;      // Beat counter, loaded with one at start
	logic [COLW-1:0] mask;      // Held wrap mask
	logic            ilv;       // Held order selection
	logic            busy;      // Burst in progress

	// Sequential wraps inside the aligned block; interleave is plain XOR
	wire [COLW-1:0] seqAddr  = (base & ~mask) | ((base + beat) & mask);
	wire [COLW-1:0] ilvAddr  = base ^ (beat & mask);
	wire [COLW-1:0] nextAddr = ilv ? ilvAddr : seqAddr;
	wire            lastBeat = (beat == mask);

	// Burst sequencing; a new start restarts the burst at full length
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			base     <= '0;
			beat     <= '0;
			mask     <= '0;
			ilv      <= 1'b0;
			busy     <= 1'b0;
			colAddr  <= '0;
			colValid <= 1'b0;
		end else if (clkEn) begin
			if (start) begin
				base     <= startAddr;
				mask     <= lenMask;
				ilv      <= interleaved;
				beat     <= COLW'(1);
				busy     <= (lenMask != '0);
				colAddr  <= startAddr;
				colValid <= 1'b1;
			end else if (busy) begin
				colAddr  <= nextAddr;
				colValid <= 1'b1;
				beat     <= beat + COLW'(1);
				busy     <= !lastBeat;
			end else begin
				colValid <= 1'b0;
			end
		end
	end

endmodule

/* design/ddr_init_mode_reg.sv */
// Mode register capture and command decoding of a DDR SDRAM device
`timescale 1ns/1ps

// Contract
// - Mode load strobes low captures address
// - Mode write occupies two clock cycles
// - Mode register rewritable when banks idle
// - Burst length from address bits 0-2
// - Order from bit 3, latency bits 4-6
// - Address bit eight requests DLL reset
// - Sequential burst wraps in aligned block
// - Interleaved burst is start XOR counter
// - Inputs sampled rising edge, chip select low
// - Extended load has bank bit zero high
module ddr_init_mode_reg (
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     clkEn,
	input  wire logic                     cke,
	input  wire ddr_mode_pkg::cmd_pins_t  cmdPins,
	input  wire logic                     bank_sel_bit0,
	input  wire logic                     bank_sel_bit1,
	input  wire logic [12:0]              addr,
	output ddr_mode_pkg::mode_fields_t    modeFields,
	output logic                          dllEnabled,
	output logic                          modeWritten,
	output logic                          extWritten,
	output logic                          modeBusy,
	output logic                          dllLocked,
	output logic                          initDone,
	output logic                          seqError,
	output logic [2:0]                    colAddr,
	output logic                          colValid
);

	// All assertions below share the core clock and the reset
	default clocking assertClk @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// Two-stage synchronisers for the pin inputs
	logic [19:0] pinMeta;        // First stage, read only by second
	logic [19:0] pinSync;        // Second stage, used by the logic

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Both stages park at deselect so no phantom command appears
			pinMeta <= 20'h0000f;
			pinSync <= 20'h0000f;
		end else if (clkEn) begin
			pinMeta <= {cke, bank_sel_bit1, bank_sel_bit0, addr, cmdPins};
			pinSync <= pinMeta;
		end
	end

	// Synchronised fields
	wire                     ckeS  = pinSync[19];
	wire                     ba1S  = pinSync[18];
	wire                     ba0S  = pinSync[17];
	wire [12:0]              addrS = pinSync[16:4];
	ddr_mode_pkg::cmd_pins_t cmdS;
	assign cmdS = pinSync[3:0];

	// Command decode; chip select high masks everything
	wire selected  = ckeS && !cmdS.csN;
	wire loadStrb  = selected && !cmdS.rasN && !cmdS.casN
	                 && !cmdS.weN;
	wire modeLoad  = loadStrb && !ba0S;
	wire extLoad   = loadStrb && ba0S;
	wire precharge = selected && !cmdS.rasN && cmdS.casN && !cmdS.weN;
	wire prechAll  = precharge && addrS[10];
	wire refresh   = selected && !cmdS.rasN && !cmdS.casN && cmdS.weN;
	wire activate  = selected && !cmdS.rasN && cmdS.casN && cmdS.weN;
	wire anyCmd    = selected && !(cmdS.rasN && cmdS.casN && cmdS.weN);
	wire readCmd   = selected && cmdS.rasN && !cmdS.casN && cmdS.weN;

	// Initialisation progress states
	typedef enum logic [2:0] {
		ST_POWER   = 3'b000,
		ST_PRE1    = 3'b001,
		ST_EXT     = 3'b010,
		ST_DLLRST  = 3'b011,
		ST_REFRESH = 3'b100,
		ST_DONE    = 3'b101
	} init_state_t;

	init_state_t     initState;      // Progress through init
	init_state_t     next_initState;
	logic            sawDllRst;      // DLL reset load seen
	logic            sawPre2;        // Second precharge seen
	logic [1:0]      refreshCnt;     // Refreshes since both seen
	logic [1:0]      mrdCnt;         // Mode write occupancy left
	logic [7:0]      lockCnt;        // DLL lock countdown
	logic            bankOpen;       // Some bank activated
	logic            lockedInt;      // DLL lock reached

	// Occupancy and misuse checks the device can observe
	wire loadBad  = (modeLoad || extLoad) && (bankOpen || !ckeS);
	wire mrdBad   = anyCmd && (mrdCnt != 2'h0);
	wire readBad  = readCmd && !lockedInt;
	wire pairDone = sawDllRst && sawPre2;

	// Next init state; deviation from the order only holds the state, seqError is not raised
	always_comb begin
		next_initState = initState;
		case (initState)
			ST_POWER:   if (ckeS) next_initState = ST_PRE1;
			ST_PRE1:    if (prechAll) next_initState = ST_EXT;
			ST_EXT:     if (extLoad && !addrS[ddr_mode_pkg::DLLEN_POS])
				next_initState = ST_DLLRST;
			ST_DLLRST:  if (pairDone) next_initState = ST_REFRESH;
			ST_REFRESH: if (modeLoad && !addrS[ddr_mode_pkg::DLLRST_POS]
			                && refreshCnt == 2'h2)
				next_initState = ST_DONE;
			ST_DONE:    next_initState = ST_DONE;
			default:    next_initState = ST_POWER;
		endcase
	end

	// Init sequencing and bookkeeping
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			initState  <= ST_POWER;
			sawDllRst  <= 1'b0;
			sawPre2    <= 1'b0;
			refreshCnt <= 2'h0;
			bankOpen   <= 1'b0;
		end else if (clkEn) begin
			initState <= next_initState;
			if (initState == ST_DLLRST && modeLoad
			    && addrS[ddr_mode_pkg::DLLRST_POS])
				sawDllRst <= 1'b1;
			if (initState == ST_DLLRST && prechAll)
				sawPre2 <= 1'b1;
			if (initState == ST_REFRESH && refresh && refreshCnt != 2'h2)
				refreshCnt <= refreshCnt + 2'h1;
			if (activate)
				bankOpen <= 1'b1;
			else if (prechAll)
				bankOpen <= 1'b0;
		end
	end

	// Mode registers capture the sampled address in the load cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			modeFields  <= '0;
			dllEnabled  <= 1'b0;
			modeWritten <= 1'b0;
			extWritten  <= 1'b0;
			mrdCnt      <= 2'h0;
		end else if (clkEn) begin
			if (modeLoad) begin
				modeFields.burstLen    <= addrS[2:0];
				modeFields.interleaved <= addrS[3];
				modeFields.readLatency <= addrS[6:4];
				modeFields.testMode    <= addrS[7];
				modeFields.dllReset    <= addrS[8];
				modeWritten            <= extWritten;
			end
			if (extLoad) begin
				dllEnabled <= !addrS[ddr_mode_pkg::DLLEN_POS];
				extWritten <= 1'b1;
			end
			if (modeLoad || extLoad)
				mrdCnt <= 2'(ddr_mode_pkg::MRD_CYCLES - 1);
			else if (mrdCnt != 2'h0)
				mrdCnt <= mrdCnt - 2'h1;
		end
	end

	// DLL lock countdown restarts on enable or DLL reset
	wire dllKick = (extLoad && !addrS[0]) || (modeLoad && addrS[8]);
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lockCnt   <= 8'h00;
			lockedInt <= 1'b0;
		end else if (clkEn) begin
			if (dllKick) begin
				lockCnt   <= 8'(ddr_mode_pkg::DLL_LOCK_CYCLES - 1);
				lockedInt <= 1'b0;
			end else if (lockCnt != 8'h00) begin
				lockCnt <= lockCnt - 8'h01;
			end else if (dllEnabled) begin
				lockedInt <= 1'b1;
			end
		end
	end

	// Status outputs, all registered; error is sticky until reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			modeBusy  <= 1'b0;
			dllLocked <= 1'b0;
			initDone  <= 1'b0;
			seqError  <= 1'b0;
		end else if (clkEn) begin
			// Busy spans the load edge and the one occupied cycle after it
			modeBusy  <= modeLoad || extLoad || (mrdCnt != 2'h0);
			dllLocked <= lockedInt;
			initDone  <= (next_initState == ST_DONE);
			if (loadBad || mrdBad || readBad)
				seqError <= 1'b1;
		end
	end

	// Burst length code to wrap mask
	wire [2:0] lenMask =
		(modeFields.burstLen == ddr_mode_pkg::BL_CODE_2) ? 3'h1 :
		(modeFields.burstLen == ddr_mode_pkg::BL_CODE_4) ? 3'h3 :
		(modeFields.burstLen == ddr_mode_pkg::BL_CODE_8) ? 3'h7 : 3'h0;

	// Column order of reads and writes follows the mode register
	burst_addr_gen #(.COLW(ddr_mode_pkg::COL_W)) u_burst (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.clkEn       (clkEn),
		.start       (readCmd || (selected && cmdS.rasN && !cmdS.casN
		              && !cmdS.weN)),
		.startAddr   (addrS[2:0]),
		.lenMask     (lenMask),
		.interleaved (modeFields.interleaved),
		.colAddr     (colAddr),
		.colValid    (colValid)
	);

	// Assertions; each label names the property it guards
	a_mode_capture: assert property (clkEn && modeLoad |=>
		modeFields.burstLen == $past(addrS[2:0]))
		else $error("mode load did not capture address");
	a_mode_latency: assert property (clkEn && modeLoad |=>
		modeFields.readLatency == $past(addrS[6:4]))
		else $error("read latency field wrong");
	a_dll_reset_bit: assert property (clkEn && modeLoad |=>
		modeFields.dllReset == $past(addrS[8]))
		else $error("DLL reset bit wrong");
	a_ext_dll_en: assert property (clkEn && extLoad |=>
		dllEnabled == !$past(addrS[0]))
		else $error("DLL enable not taken");
	// Busy must cover both cycles of the write, not only the load edge
	a_mrd_busy: assert property (clkEn && (modeLoad || extLoad) |=>
		modeBusy [*2])
		else $error("mode write not busy for two cycles");
	a_lock_wait: assert property (clkEn && dllKick |=> !lockedInt)
		else $error("lock not restarted");
	// A deselected cycle must leave the programmed state untouched
	a_masked_cs: assert property (clkEn && cmdS.csN |=>
		$stable(modeFields) && $stable(dllEnabled))
		else $error("command taken with chip select high");
	// A new read may cut a burst short, so only plain beats are checked
	a_ilv_order: assert property (clkEn && u_burst.busy && u_burst.ilv
		&& !u_burst.start |=> colAddr ==
		($past(u_burst.base) ^ $past(u_burst.beat & u_burst.mask)))
		else $error("interleaved address wrong");
	a_seq_block: assert property (clkEn && u_burst.busy && !u_burst.ilv
		&& !u_burst.start |=> (colAddr & ~$past(u_burst.mask)) ==
		($past(u_burst.base) & ~$past(u_burst.mask)))
		else $error("sequential burst left block");
	a_init_gate: assert property (initState == ST_POWER |-> !initDone)
		else $error("init done too early");

	c_init_done: cover property (@(posedge core_clk) $rose(initDone));
	c_dll_lock: cover property (@(posedge core_clk) $rose(dllLocked));
	c_burst_ilv: cover property (@(posedge core_clk)
		colValid && modeFields.interleaved);
	c_seq_err: cover property (@(posedge core_clk) $rose(seqError));

endmodule

/* bench/ddr_ctrl_model.sv */
// Memory controller model driving DRAM command and address pins
`timescale 1ns/1ps

module ddr_ctrl_model #(
	parameter int PWR_WAIT = 40000, // 200us of clock at 5 ns
	parameter int GAP      = 5      // Idle edges after a command
) (
	input  wire logic                core_clk,
	output logic                     cke,
	output ddr_mode_pkg::cmd_pins_t  cmdPins,
	output logic                     bank_sel_bit0,
	output logic                     bank_sel_bit1,
	output logic [12:0]              addr
);
	// Strobe codes in csN, rasN, casN, weN order
	localparam logic [3:0] LOAD = 4'h0;
	localparam logic [3:0] REF  = 4'h1;
	localparam logic [3:0] PRE  = 4'h2;
	localparam logic [3:0] ACT  = 4'h3;
	localparam logic [3:0] RD   = 4'h5;
	localparam logic [3:0] NOP  = 4'h7;
	localparam logic [3:0] DSEL = 4'hf;

	// Gate low from power-up, other pins parked
	initial begin
		cke = 1'b0;
		cmdPins = DSEL;
		{bank_sel_bit0, bank_sel_bit1, addr} = 15'h0000;
	end

	// One command for one edge, then deselect; released pins show
	// the inverse of the last value so nothing stale looks valid
	task automatic issue(input logic [3:0] c, input logic b0,
		input logic [12:0] a);
		@(posedge core_clk);
		#1;
		cmdPins = c;
		{bank_sel_bit0, bank_sel_bit1, addr} = {b0, 1'b0, a};
		@(posedge core_clk);
		#1;
		cmdPins = DSEL;
		{bank_sel_bit0, bank_sel_bit1, addr} = ~{b0, 1'b0, a};
		// Spacing covers the two-cycle load and precharge recovery
		repeat (GAP) @(posedge core_clk);
		// Return off the edge so callers never race registered outputs
		#1;
	endtask

	// Ordered power-up; swap puts the second precharge first
	task automatic init_seq(input bit swap, input logic [12:0] mode);
		#1;
		cke = 1'b0;
		cmdPins = DSEL;
		repeat (PWR_WAIT) @(posedge core_clk);
		#1;
		cmdPins = NOP;
		cke = 1'b1;
		issue(PRE, 1'b0, 13'h0400);
		issue(LOAD, 1'b1, 13'h0000);
		if (swap) issue(PRE, 1'b0, 13'h0400);
		issue(LOAD, 1'b0, mode | 13'h0100);
		if (!swap) issue(PRE, 1'b0, 13'h0400);
		repeat (200) @(posedge core_clk);
		issue(REF, 1'b0, 13'h0000);
		issue(REF, 1'b0, 13'h0000);
		issue(LOAD, 1'b0, mode & 13'h1eff);
	endtask
endmodule

/* bench/ddr_init_and_mode_register_bench.sv */
// Testbench: power-up order, mode loads and burst ordering
`timescale 1ns/1ps

module ddr_init_and_mode_register_bench;
	logic                        core_clk;    // 200 MHz clock
	logic                        sys_rst;     // Async reset
	logic                        clkEn;       // Held high throughout
	logic                        cke;         // Gate from the model
	ddr_mode_pkg::cmd_pins_t     cmdPins;     // Command strobes
	logic                        bank_sel_bit0;
	logic                        bank_sel_bit1;
	logic [12:0]                 addr;
	ddr_mode_pkg::mode_fields_t  modeFields;  // Decoded mode word
	logic                        dllEnabled;
	logic                        modeWritten;
	logic                        extWritten;
	logic                        modeBusy;
	logic                        dllLocked;
	logic                        initDone;
	logic                        seqError;
	logic [2:0]                  colAddr;
	logic                        colValid;
	int                          errors;      // Mismatch count
	int                          num_checks;  // Comparison count
	int                          busyRun = 0;  // Current busy length
	int                          lastBusy = 0; // Length of last busy run
	logic [2:0]                  beats[$];    // Columns seen per beat

	ddr_ctrl_model ctrl_u (.core_clk(core_clk), .cke(cke),
		.cmdPins(cmdPins), .bank_sel_bit0(bank_sel_bit0),
		.bank_sel_bit1(bank_sel_bit1), .addr(addr));

	ddr_init_mode_reg dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
		.clkEn(clkEn), .cke(cke), .cmdPins(cmdPins),
		.bank_sel_bit0(bank_sel_bit0), .bank_sel_bit1(bank_sel_bit1),
		.addr(addr), .modeFields(modeFields), .dllEnabled(dllEnabled),
		.modeWritten(modeWritten), .extWritten(extWritten),
		.modeBusy(modeBusy), .dllLocked(dllLocked),
		.initDone(initDone), .seqError(seqError),
		.colAddr(colAddr), .colValid(colValid));

	// Half period of 2.5 ns
	always #2.5 core_clk = ~core_clk;

	// Measure each busy run and log burst beats
	always @(posedge core_clk) begin
		if (modeBusy === 1'b1) begin
			busyRun <= busyRun + 1;
		end else if (busyRun != 0) begin
			lastBusy <= busyRun;
			busyRun <= 0;
		end else if (cmdPins.csN === 1'b0) begin
			// A new command forgets the old run, so a silent load shows 0
			lastBusy <= 0;
		end
		if (colValid === 1'b1) begin
			beats.push_back(colAddr);
		end
	end

	// Compare and count; unknowns never match
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Reset for 12 cycles, released just after an edge
	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (12) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
	endtask

	// Field layout the mode word should decode to
	function automatic logic [15:0] exp_fields(input logic [12:0] a);
		return {7'h00, a[2:0], a[3], a[6:4], a[7], a[8]};
	endfunction

	// Activate, read from start, compare beats, close all banks
	task automatic burst(input logic [2:0] start, input int len,
		input bit il);
		logic [2:0] mask;
		logic [2:0] exp;
		int         n;
		mask = 3'(len - 1);
		beats.delete();
		ctrl_u.issue(ctrl_u.ACT, 1'b0, 13'h0000);
		ctrl_u.issue(ctrl_u.RD, 1'b0, {10'h000, start});
		n = 0;
		while (beats.size() < len && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		if (beats.size() < len) begin
			errors++;
			final_report();
		end
		// Room for a stray extra beat to show up
		repeat (4) @(posedge core_clk);
		check("beat count", 16'(len), 16'(beats.size()));
		for (int i = 0; i < len; i++) begin
			if (il) begin
				exp = start ^ 3'(i);
			end else begin
				exp = ((start + 3'(i)) & mask) | (start & ~mask);
			end
			check("burst column", {13'h0, exp}, {13'h0, beats[i]});
		end
		ctrl_u.issue(ctrl_u.PRE, 1'b0, 13'h0400);
	endtask

	// Main sequence
	initial begin
		logic [12:0] a;
		core_clk = 1'b0;
		clkEn = 1'b1;
		errors = 0;
		num_checks = 0;
		do_reset();
		check("fields at reset", 16'h0000, 16'(modeFields));
		check("done at reset", 16'h0000, {15'h0, initDone});
		ctrl_u.init_seq(1'b0, 13'h0022);
		check("init done", 16'h0001, {15'h0, initDone});
		check("dll enabled", 16'h0001, {15'h0, dllEnabled});
		check("ext written", 16'h0001, {15'h0, extWritten});
		check("mode written", 16'h0001, {15'h0, modeWritten});
		check("dll locked", 16'h0001, {15'h0, dllLocked});
		check("fields", exp_fields(13'h0022), 16'(modeFields));
		check("busy cycles", 16'h0002, 16'(lastBusy));
		check("no misuse", 16'h0000, {15'h0, seqError});
		$display("test power-up order done");
		// Code 0 is unsupported and must give a single beat
		for (int code = 0; code < 4; code++) begin
			for (int il = 0; il < 2; il++) begin
				a = {4'h0, 1'b0, 1'b0, 3'h2, 1'(il), 3'(code)};
				ctrl_u.issue(ctrl_u.LOAD, 1'b0, a);
				check("fields", exp_fields(a), 16'(modeFields));
				check("busy cycles", 16'h0002, 16'(lastBusy));
				burst(3'h1, 1 << code, il[0]);
				burst(3'h6, 1 << code, il[0]);
			end
		end
		check("no misuse", 16'h0000, {15'h0, seqError});
		$display("test burst orders done");
		ctrl_u.issue(ctrl_u.ACT, 1'b0, 13'h0000);
		ctrl_u.issue(ctrl_u.LOAD, 1'b0, 13'h0022);
		check("load with open bank", 16'h0001, {15'h0, seqError});
		$display("test open bank load done");
		do_reset();
		check("error cleared", 16'h0000, {15'h0, seqError});
		ctrl_u.init_seq(1'b1, 13'h003b);
		check("swapped init", 16'h0001, {15'h0, initDone});
		check("fields", exp_fields(13'h003b), 16'(modeFields));
		check("no misuse", 16'h0000, {15'h0, seqError});
		$display("test swapped order done");
		final_report();
	end
endmodule
